// ==== hw/dual_port_buffer_manager.sv ====
// Buffer manager: register decode, buffer port arbitration, address modes,
// host handshake and SCSI arbitration timing.
// Assumes single-cycle processor strobes synchronous to clk, one access outstanding.
`include "buffer_manager_consts.svh"
module dual_port_buffer_manager (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Processor register port
  input  wire logic [7:0]  cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_rvalid,
  // Buffer RAM
  output logic      [13:0] buf_addr,
  output logic             memory_select_n,
  output logic             buf_write_n,
  input  wire logic [7:0]  buf_data_in,
  output logic      [7:0]  buf_data_out,
  output logic             buf_data_oe_n,
  // Host port
  input  wire logic [15:0] host_data_in,
  output logic      [1:0]  latch_out_strobe,
  output logic             host_inbound_gate_n,
  output logic             host_outbound_gate_n,
  output logic             host_req,
  input  wire logic        host_ack,
  // Disk port
  input  wire logic        disk_byte_request_n,
  // SCSI arbitration
  input  wire logic        bsy_in,
  input  wire logic        sel_in,
  output logic             busy_out,
  output logic             select_out
);
  import buffer_manager_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    return a == t;
  endfunction : hit

  function automatic logic [15:0] upd_ptr(input logic [15:0] p, input logic wl, input logic wh,
                                          input logic inc, input logic clr, input logic [7:0] d,
                                          input logic [15:0] mask);
    logic [15:0] r;
    r = p;
    if (clr) begin
      r = `ZERO16;
    end else if (wl) begin
      r = {p[15:8], d};
    end else if (wh) begin
      r = {d, p[7:0]};
    end else if (inc) begin
      r = (p + 16'h0001) & mask;
    end
    return r;
  endfunction : upd_ptr

  function automatic logic [13:0] pin_map(input logic [15:0] p, input addr_mode_t m, input logic host_page_latch_strobe,
                                          input logic disk_page_latch_strobe, input logic hoe_n, input logic doe_n);
    logic [13:0] r;
    r = {doe_n, hoe_n, 2'b00, p[9:0]};
    unique case (m)
      MODE_MIN: r = {doe_n, hoe_n, 2'b00, p[9:0]};
      MODE_EXT: r = p[13:0];
      MODE_MAX: r = {doe_n, hoe_n, p[11:10], disk_page_latch_strobe, host_page_latch_strobe, p[7:0]};
    endcase
    return r;
  endfunction : pin_map

  logic [7:0]  hctrl_ff, dma_ff, bsize_ff, amode_ff;
  logic [15:0] rap_ff, wap_ff, stop_ff;
  logic [7:0]  host_pg_ff, disk_pg_ff;
  logic        disk_pend_ff, cpu_pend_ff, cpu_pwr_ff, cpu_rtag_ff;
  logic [7:0]  cpu_pdata_ff;
  logic [2:0]  free_cnt_ff, arb_cnt_ff;
  logic        ok_arb_ff;
  host_state_t hst_ff, nxt_hst;

  // Address decode
  wire wr_lo    = cpu_wr && hit(cpu_addr, `A_HOST_LO);
  wire wr_hi    = cpu_wr && hit(cpu_addr, `A_HOST_HI);
  wire wr_hctrl = cpu_wr && hit(cpu_addr, `A_HCTRL);
  wire wr_dma   = cpu_wr && hit(cpu_addr, `A_DMA);
  wire wr_bsize = cpu_wr && hit(cpu_addr, `A_BSIZE);
  wire wr_amode = cpu_wr && hit(cpu_addr, `A_AMODE);
  wire wr_reset = cpu_wr && hit(cpu_addr, `A_RESET);
  wire wr_rap_l = cpu_wr && hit(cpu_addr, `A_RAP_L);
  wire wr_rap_h = cpu_wr && hit(cpu_addr, `A_RAP_H);
  wire wr_wap_l = cpu_wr && hit(cpu_addr, `A_WAP_L);
  wire wr_wap_h = cpu_wr && hit(cpu_addr, `A_WAP_H);
  wire wr_sp_l  = cpu_wr && hit(cpu_addr, `A_STOP_L);
  wire wr_sp_h  = cpu_wr && hit(cpu_addr, `A_STOP_H);
  wire win_wr   = cpu_wr && hit(cpu_addr, `A_BUFWIN);
  wire win_rd   = cpu_rd && hit(cpu_addr, `A_BUFWIN);
  wire soft_all = wr_reset && cpu_wdata[`RST_ALL];

  // Addressing mode
  wire        dir      = dma_ff[`DMA_DIR];
  wire        ext      = amode_ff[`AM_EXT];
  wire        max_mode = ext ? (bsize_ff > `BSIZE_EXT_LIM) : (bsize_ff > `BSIZE_MIN_LIM);
  wire addr_mode_t mode = max_mode ? MODE_MAX : (ext ? MODE_EXT : MODE_MIN);
  wire [15:0] size_mask = {bsize_ff, `LOW_MASK};

  // Host uses the read pointer on disk reads, the disk port the other one
  wire [15:0] host_ptr = dir ? rap_ff : wap_ff;
  wire [15:0] disk_ptr = dir ? wap_ff : rap_ff;
  wire [15:0] win_ptr  = dir ? wap_ff : rap_ff;

  // In max mode, page latches are reloaded whenever a pointer upper byte differs from them
  wire hp_pend = max_mode && (host_ptr[15:8] != host_pg_ff);
  wire dp_pend = max_mode && (disk_ptr[15:8] != disk_pg_ff);

  // Buffer cycle arbitration
  wire disk_cyc    = disk_pend_ff;
  wire strobe_cyc  = !disk_cyc && (hp_pend || dp_pend);
  wire strobe_host = strobe_cyc && hp_pend;
  wire strobe_disk = strobe_cyc && !hp_pend;
  wire cpu_cyc     = !disk_cyc && !strobe_cyc && cpu_pend_ff;
  wire host_cyc    = !disk_cyc && !strobe_cyc && !cpu_pend_ff && (hst_ff == H_MEM);

  wire [15:0] cyc_ptr = disk_cyc    ? disk_ptr :
                        cpu_cyc     ? win_ptr :
                        host_cyc    ? host_ptr :
                        strobe_host ? {`ZERO8, host_ptr[15:8]} : {`ZERO8, disk_ptr[15:8]};
  wire [13:0] nxt_pins = pin_map(cyc_ptr, mode, strobe_host, strobe_disk,
                                 !host_cyc, !(disk_cyc || cpu_cyc));
  wire nxt_ms_n = !(disk_cyc || cpu_cyc || host_cyc);
  wire nxt_we_n = !((disk_cyc && dir) || (cpu_cyc && cpu_pwr_ff) || (host_cyc && !dir));
  wire cpu_drive = cpu_cyc && cpu_pwr_ff;

  // Host handshake
  wire dma_active  = dir ? dma_ff[`DMA_RL] : dma_ff[`DMA_WL];
  wire ptr_at_stop = (host_ptr & size_mask) == (stop_ff & size_mask);
  wire done_set    = dma_active && ptr_at_stop && (hst_ff == H_IDLE);
  wire host_inc    = dir ? ((hst_ff == H_REQ) && host_ack) : host_cyc;
  wire inc_rap     = (disk_cyc && !dir) || (host_inc && dir);
  wire inc_wap     = (disk_cyc && dir) || (host_inc && !dir);
  wire dma_in      = !dir && ((nxt_hst == H_REQ) || (nxt_hst == H_MEM));
  wire dma_out     = dir && (nxt_hst == H_REQ);

  always_comb begin
    nxt_hst = hst_ff;
    unique case (hst_ff)
      H_IDLE: begin
        if (dma_active && !ptr_at_stop) begin
          nxt_hst = dir ? H_MEM : H_REQ;
        end
      end
      H_MEM: begin
        if (host_cyc) begin
          nxt_hst = dir ? H_REQ : H_ACK;
        end
      end
      H_REQ: begin
        if (host_ack) begin
          nxt_hst = dir ? H_ACK : H_MEM;
        end
      end
      H_ACK: begin
        if (!host_ack) begin
          nxt_hst = H_IDLE;
        end
      end
    endcase
  end

  // SCSI bus free search and arbitration delay
  wire bus_idle    = !bsy_in && !sel_in;
  wire bus_free    = free_cnt_ff == `FREE_CYCLES;
  wire arbitrating = ok_arb_ff && (arb_cnt_ff == `ARB_DELAY);
  wire [2:0] nxt_free = !bus_idle ? 3'h0 : (bus_free ? free_cnt_ff : free_cnt_ff + 3'h1);
  wire [2:0] nxt_arb  = !ok_arb_ff ? 3'h0 : (arbitrating ? arb_cnt_ff : arb_cnt_ff + 3'h1);
  // Request survives a busy bus and lost arbitration; setting select retires it
  wire [7:0] nxt_hctrl = wr_hctrl ? (cpu_wdata[`HC_SEL] ? (cpu_wdata & 8'hFE) : cpu_wdata) : hctrl_ff;

  // Register read mux
  wire [7:0] rd_mux =
    hit(cpu_addr, `A_HOST_LO) ? (hctrl_ff[`HC_BIE] ? host_data_in[7:0] : `ZERO8) :
    hit(cpu_addr, `A_HOST_HI) ? (hctrl_ff[`HC_BIE] ? host_data_in[15:8] : `ZERO8) :
    hit(cpu_addr, `A_HCTRL)   ? {hctrl_ff[7:6], bsy_in, hctrl_ff[4:1], arbitrating} :
    hit(cpu_addr, `A_DMA)     ? dma_ff :
    hit(cpu_addr, `A_BSIZE)   ? bsize_ff :
    hit(cpu_addr, `A_AMODE)   ? amode_ff :
    hit(cpu_addr, `A_RAP_L)   ? rap_ff[7:0] :
    hit(cpu_addr, `A_RAP_H)   ? rap_ff[15:8] :
    hit(cpu_addr, `A_WAP_L)   ? wap_ff[7:0] :
    hit(cpu_addr, `A_WAP_H)   ? wap_ff[15:8] :
    hit(cpu_addr, `A_STOP_L)  ? stop_ff[7:0] :
    hit(cpu_addr, `A_STOP_H)  ? stop_ff[15:8] : `ZERO8;

  wire [7:0] nxt_dma = done_set ? (dma_ff | 8'h20) : (wr_dma ? cpu_wdata : dma_ff);

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hctrl_ff <= `ZERO8;
      dma_ff   <= `ZERO8;
      bsize_ff <= `ZERO8;
      amode_ff <= `ZERO8;
    end else if (soft_all) begin
      hctrl_ff <= `ZERO8;
      dma_ff   <= `ZERO8;
      bsize_ff <= `ZERO8;
      amode_ff <= `ZERO8;
    end else begin
      hctrl_ff <= nxt_hctrl;
      dma_ff   <= nxt_dma;
      bsize_ff <= wr_bsize ? cpu_wdata : bsize_ff;
      amode_ff <= wr_amode ? cpu_wdata : amode_ff;
    end
  end

  // Pointers; processor writes win over increments
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rap_ff  <= `ZERO16;
      wap_ff  <= `ZERO16;
      stop_ff <= `ZERO16;
    end else begin
      rap_ff  <= upd_ptr(rap_ff, wr_rap_l, wr_rap_h, inc_rap, wr_reset, cpu_wdata, size_mask);
      wap_ff  <= upd_ptr(wap_ff, wr_wap_l, wr_wap_h, inc_wap, wr_reset, cpu_wdata, size_mask);
      stop_ff <= upd_ptr(stop_ff, wr_sp_l, wr_sp_h, 1'b0, wr_reset, cpu_wdata, size_mask);
    end
  end

  // Page latch shadows, disk sample, window request, handshake, arbitration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_pg_ff   <= `ZERO8;
      disk_pg_ff   <= `ZERO8;
      disk_pend_ff <= 1'b0;
      cpu_pend_ff  <= 1'b0;
      cpu_pwr_ff   <= 1'b0;
      cpu_pdata_ff <= `ZERO8;
      cpu_rtag_ff  <= 1'b0;
      hst_ff       <= H_IDLE;
      free_cnt_ff  <= 3'h0;
      arb_cnt_ff   <= 3'h0;
      ok_arb_ff    <= 1'b0;
    end else begin
      host_pg_ff   <= strobe_host ? host_ptr[15:8] : host_pg_ff;
      disk_pg_ff   <= strobe_disk ? disk_ptr[15:8] : disk_pg_ff;
      disk_pend_ff <= !disk_byte_request_n;
      cpu_pend_ff  <= win_rd || win_wr || (cpu_pend_ff && !cpu_cyc);
      cpu_pwr_ff   <= (win_rd || win_wr) ? win_wr : cpu_pwr_ff;
      cpu_pdata_ff <= win_wr ? cpu_wdata : cpu_pdata_ff;
      cpu_rtag_ff  <= cpu_cyc && !cpu_pwr_ff;
      hst_ff       <= nxt_hst;
      free_cnt_ff  <= nxt_free;
      arb_cnt_ff   <= nxt_arb;
      ok_arb_ff    <= !sel_in && (ok_arb_ff || (bus_free && hctrl_ff[`HC_ARB]));
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_addr             <= 14'h3000;
      memory_select_n      <= 1'b1;
      buf_write_n          <= 1'b1;
      buf_data_out         <= `ZERO8;
      buf_data_oe_n        <= 1'b1;
      latch_out_strobe     <= 2'b00;
      host_inbound_gate_n  <= 1'b1;
      host_outbound_gate_n <= 1'b1;
      host_req             <= 1'b0;
      busy_out             <= 1'b0;
      select_out           <= 1'b0;
      cpu_rdata            <= `ZERO8;
      cpu_rvalid           <= 1'b0;
    end else begin
      buf_addr             <= nxt_pins;
      memory_select_n      <= nxt_ms_n;
      buf_write_n          <= nxt_we_n;
      buf_data_out         <= cpu_drive ? cpu_pdata_ff : cpu_wdata;
      buf_data_oe_n        <= !(cpu_drive || wr_lo || wr_hi);
      latch_out_strobe     <= {wr_hi, wr_lo || (host_cyc && dir)};
      host_inbound_gate_n  <= !(nxt_hctrl[`HC_BIE] || dma_in);
      host_outbound_gate_n <= !(nxt_hctrl[`HC_BOE] || dma_out || arbitrating);
      host_req             <= nxt_hst == H_REQ;
      busy_out             <= nxt_hctrl[`HC_BSY] || arbitrating;
      select_out           <= nxt_hctrl[`HC_SEL];
      cpu_rdata            <= cpu_rtag_ff ? buf_data_in : rd_mux;
      cpu_rvalid           <= cpu_rtag_ff || (cpu_rd && !win_rd);
    end
  end

endmodule : dual_port_buffer_manager

// ==== shared/buffer_manager_consts.svh ====
// Register offsets, field positions and timing counts of the buffer manager.
// Assumes an 8-bit processor register port and one clock for all logic.
`ifndef BUFFER_MANAGER_CONSTS_SVH
`define BUFFER_MANAGER_CONSTS_SVH

`define A_HOST_LO  8'h50
`define A_HOST_HI  8'h51
`define A_HCTRL    8'h52
`define A_DMA      8'h53
`define A_BSIZE    8'h54
`define A_AMODE    8'h55
`define A_RESET    8'h59
`define A_RAP_L    8'h5A
`define A_RAP_H    8'h5B
`define A_WAP_L    8'h5C
`define A_WAP_H    8'h5D
`define A_STOP_L   8'h5E
`define A_STOP_H   8'h5F
`define A_BUFWIN   8'h70

`define HC_ARB     0
`define HC_BIE     2
`define HC_BOE     3
`define HC_BSYIN   5
`define HC_SEL     6
`define HC_BSY     7
`define DMA_WL     1
`define DMA_RL     2
`define DMA_DIR    4
`define DMA_DONE   5
`define AM_EXT     0
`define RST_ALL    0

`define BSIZE_MIN_LIM 8'h03
`define BSIZE_EXT_LIM 8'h3F
`define LOW_MASK      8'hFF
`define ZERO8         8'h00
`define ZERO16        16'h0000

`define FREE_CYCLES 3'h3
`define ARB_DELAY   3'h4

`endif

// ==== shared/buffer_manager_pkg.sv ====
// Types shared by the buffer manager design and its bench.
// Assumes nothing beyond SystemVerilog enums.
package buffer_manager_pkg;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_MEM  = 2'b01,
    H_REQ  = 2'b10,
    H_ACK  = 2'b11
  } host_state_t;

  typedef enum logic [1:0] {
    MODE_MIN = 2'b00,
    MODE_EXT = 2'b01,
    MODE_MAX = 2'b10
  } addr_mode_t;

endpackage : buffer_manager_pkg

// ==== tb/buffer_manager_checker_asserts.sv ====
// Port-level assertions for the buffer manager.
// Assumes one-cycle processor strobes and the reset values of the hand-over.
`include "buffer_manager_consts.svh"
module buffer_manager_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Processor
  input wire logic [7:0]  cpu_addr,
  input wire logic        cpu_rd,
  input wire logic        cpu_wr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic        cpu_rvalid,
  // Buffer and host
  input wire logic [13:0] buf_addr,
  input wire logic        memory_select_n,
  input wire logic        buf_write_n,
  input wire logic [7:0]  buf_data_out,
  input wire logic [1:0]  latch_out_strobe,
  input wire logic        host_req,
  input wire logic        host_ack,
  // Disk and SCSI
  input wire logic        disk_byte_request_n,
  input wire logic        bsy_in,
  input wire logic        sel_in,
  input wire logic        busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] free_ff;
  logic [3:0] nxt_free;
  // Saturates so a long idle bus never wraps
  assign nxt_free = (bsy_in || sel_in) ? 4'h0 : free_ff + {3'h0, free_ff != 4'hF};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) free_ff <= 4'h0;
    else free_ff <= nxt_free;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_answer; cpu_rd && cpu_addr != `A_BUFWIN |=> cpu_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("register read not answered");
  property p_win_rd; cpu_rd && cpu_addr == `A_BUFWIN |-> ##[2:12] (!memory_select_n && buf_write_n); endproperty
  a_win_rd: assert property (p_win_rd) else $error("window read gave no select");
  property p_win_wr; cpu_wr && cpu_addr == `A_BUFWIN |-> ##[2:12] (!memory_select_n && !buf_write_n); endproperty
  a_win_wr: assert property (p_win_wr) else $error("window write gave no strobe");
  property p_lo_latch; cpu_wr && cpu_addr == `A_HOST_LO |=> latch_out_strobe == 2'h1 && buf_data_out == $past(cpu_wdata);
  endproperty
  a_lo_latch: assert property (p_lo_latch) else $error("low latch strobe wrong");
  property p_hi_latch; cpu_wr && cpu_addr == `A_HOST_HI |=> latch_out_strobe == 2'h2 && buf_data_out == $past(cpu_wdata);
  endproperty
  a_hi_latch: assert property (p_hi_latch) else $error("high latch strobe wrong");
  // Request is registered once, then the select pin is registered: two edges
  property p_disk_first; !disk_byte_request_n |-> ##2 !memory_select_n; endproperty
  a_disk_first: assert property (p_disk_first) else $error("disk byte not served in time");
  property p_write_sel; !buf_write_n |-> !memory_select_n; endproperty
  a_write_sel: assert property (p_write_sel) else $error("write strobe without select");
  property p_req_drop; host_req && host_ack |-> ##[1:2] !host_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after acknowledge");
  property p_arb_wait; $rose(busy_out) && !$past(cpu_wr) && !$past(cpu_wr, 2) |-> free_ff >= 4'h6; endproperty
  a_arb_wait: assert property (p_arb_wait) else $error("arbitration began too early");
  // First edge may still show pins before the reset branch has run
  property p_reset_pins;
    disable iff (1'b0) rst && $past(rst) |-> buf_addr == 14'h3000 && memory_select_n && buf_write_n;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins wrong in reset");
  c_win_rd: cover property (!memory_select_n && buf_write_n && !disk_byte_request_n);
  c_shake: cover property (host_req && host_ack);
  c_arb: cover property ($rose(busy_out));
  c_page: cover property (memory_select_n && buf_addr[8]);
endmodule : buffer_manager_checker

bind dual_port_buffer_manager buffer_manager_checker chk_u (
  .clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rvalid, .buf_addr, .memory_select_n,
  .buf_write_n, .buf_data_out, .latch_out_strobe, .host_req, .host_ack, .disk_byte_request_n,
  .bsy_in, .sel_in, .busy_out
);

// ==== tb/sram_buffer_model.sv ====
// Static RAM buffer with external page latches on the far side of the buffer pins.
// Assumes the bench tells it which addressing mode is programmed.
module sram_buffer_model (
  // Clock
  input  wire logic                           clk,
  // RAM pins
  input  wire logic [13:0]                    buf_addr,
  input  wire logic                           memory_select_n,
  input  wire logic                           buf_write_n,
  input  wire logic [7:0]                     buf_data_out,
  output logic      [7:0]                     buf_data_in,
  // Bench side
  input  wire buffer_manager_pkg::addr_mode_t mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import buffer_manager_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [7:0]  host_page_ff = 8'h00;
  logic [7:0]  disk_page_ff = 8'h00;
  logic [7:0]  last_ff = 8'h00;
  logic [15:0] addr;
  logic        rd_cyc;
  assign addr = (mode == MODE_MIN) ? {6'h00, buf_addr[9:0]} : (mode == MODE_EXT) ? {2'h0, buf_addr}
              : {buf_addr[12] ? disk_page_ff : host_page_ff, buf_addr[7:0]};
  assign rd_cyc = !memory_select_n && buf_write_n;
  // Released bus shows the inverse of its last value, not a held copy
  assign buf_data_in = rd_cyc ? mem[addr] : ~last_ff;
  always @(posedge clk) begin
    if (rd_cyc) last_ff <= mem[addr];
    if (!memory_select_n && !buf_write_n) mem[addr] <= buf_data_out;
    if (mode == MODE_MAX && memory_select_n && buf_addr[8]) host_page_ff <= buf_addr[7:0];
    if (mode == MODE_MAX && memory_select_n && buf_addr[9]) disk_page_ff <= buf_addr[7:0];
  end
endmodule : sram_buffer_model

// ==== tb/dual_port_buffer_manager_tb.sv ====
// Self-checking bench for the buffer manager with a RAM model on the buffer pins.
// Assumes a 25 MHz clock and a host that acknowledges one cycle after each request.
`include "buffer_manager_consts.svh"
module dual_port_buffer_manager_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import buffer_manager_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cpu_rd = 1'b0;
  logic        cpu_wr = 1'b0;
  logic [7:0]  cpu_addr = 8'h00;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [15:0] host_data_in = 16'h0000;
  logic        host_ack = 1'b0;
  logic        disk_byte_request_n = 1'b1;
  logic        bsy_in = 1'b0;
  logic        sel_in = 1'b0;
  addr_mode_t  mode = MODE_MIN;
  logic [7:0]  cpu_rdata, buf_data_in, buf_data_out, d;
  logic [13:0] buf_addr;
  logic [1:0]  latch_out_strobe;
  logic        cpu_rvalid, memory_select_n, buf_write_n, buf_data_oe_n, req_d = 1'b0;
  logic        host_inbound_gate_n, host_outbound_gate_n, host_req, busy_out, select_out;
  logic [15:0] a;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0, n_compared = 0, seed = 80061, cyc = 0, n_req = 0, k;

  always #20 clk = ~clk;

  dual_port_buffer_manager dut_u (.clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_rvalid,
    .buf_addr, .memory_select_n, .buf_write_n, .buf_data_in, .buf_data_out, .buf_data_oe_n, .host_data_in,
    .latch_out_strobe, .host_inbound_gate_n, .host_outbound_gate_n, .host_req, .host_ack,
    .disk_byte_request_n, .bsy_in, .sel_in, .busy_out, .select_out);
  sram_buffer_model ram_u (.clk, .buf_addr, .memory_select_n, .buf_write_n, .buf_data_out, .buf_data_in, .mode);

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    cpu_addr = ad;
    cpu_wdata = dt;
    cpu_wr = 1'b1;
    @(posedge clk) #1;
    cpu_wr = 1'b0;
    if (ad == `A_BUFWIN)
      for (k = 0; k < 16 && buf_write_n !== 1'b0; k++) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    cpu_addr = ad;
    cpu_rd = 1'b1;
    @(posedge clk) #1;
    cpu_rd = 1'b0;
    for (k = 0; k < 20 && cpu_rvalid !== 1'b1; k++) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask : rd

  task automatic setp(input logic [7:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 8'h01, v[15:8]);
  endtask : setp

  // One byte every second cycle, the fastest the disk side may go
  task automatic disk(input int n);
    repeat (n) begin
      disk_byte_request_n = 1'b0;
      @(posedge clk) #1;
      disk_byte_request_n = 1'b1;
      @(posedge clk) #1;
    end
  endtask : disk

  always @(negedge clk)
    if (cpu_rvalid === 1'b1) chk("cpu_rdata", {8'h00, exp_q.pop_front()}, {8'h00, cpu_rdata});

  always @(posedge clk) begin
    host_ack <= host_req;
    req_d <= host_req;
    if (host_req === 1'b1 && req_d === 1'b0) n_req++;
    cyc++;
    if (cyc == 20000) begin
      chk("run_time", 16'h0000, 16'h0001);
      wrap_up();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 chk("rst_pins", 16'h3000, {2'h0, buf_addr});
    rst = 1'b0;
    @(posedge clk) #1;
    wr(`A_BSIZE, 8'hFF);
    for (int i = 10; i < 16; i++) begin
      d = $random(seed);
      wr(8'h50 + 8'(i), d);
      rd(8'h50 + 8'(i), d);
    end
    rd(8'h60, 8'h00);
    rd(`A_RESET, 8'h00);
    wr(`A_BSIZE, 8'h00);
    a = $random(seed);
    d = $random(seed);
    wr(`A_DMA, 8'h00);
    setp(`A_RAP_L, {6'h00, a[9:0]});
    wr(`A_BUFWIN, d);
    rd(`A_BUFWIN, d);
    wr(`A_DMA, 8'h10);
    setp(`A_WAP_L, {6'h00, a[9:0]});
    rd(`A_BUFWIN, d);
    wr(`A_AMODE, 8'h01);
    mode = MODE_EXT;
    a = {3'h1, a[12:0]};
    d = $random(seed);
    setp(`A_WAP_L, a);
    wr(`A_BUFWIN, d);
    rd(`A_BUFWIN, d);
    host_data_in = $random(seed);
    wr(`A_HCTRL, 8'h0C);
    chk("gates", 16'h0000, {14'h0, host_inbound_gate_n, host_outbound_gate_n});
    rd(`A_HOST_LO, host_data_in[7:0]);
    rd(`A_HOST_HI, host_data_in[15:8]);
    wr(`A_HCTRL, 8'h00);
    rd(`A_HOST_LO, 8'h00);
    wr(`A_HOST_LO, d);
    wr(`A_HOST_HI, d);
    wr(`A_DMA, 8'h00);
    // 512-byte buffer so increments past 0x100 do not wrap to page zero
    wr(`A_BSIZE, 8'h01);
    d = $random(seed);
    for (int i = 0; i < 8; i++) begin
      setp(`A_RAP_L, 16'h0100 + 16'(i));
      wr(`A_BUFWIN, d);
    end
    setp(`A_RAP_L, 16'h0100);
    fork
      rd(`A_BUFWIN, d);
      disk(6);
    join
    rd(`A_RAP_L, 8'h06);
    wr(`A_AMODE, 8'h00);
    wr(`A_RESET, 8'h00);
    wr(`A_BSIZE, 8'h04);
    mode = MODE_MAX;
    wr(`A_RAP_H, 8'h02);
    for (k = 0; k < 12 && (buf_addr[8] | buf_addr[9]) !== 1'b1; k++) @(posedge clk) #1;
    chk("page_strobe", 16'h0002, {8'h00, buf_addr[7:0]});
    wr(`A_BSIZE, 8'h00);
    mode = MODE_MIN;
    bsy_in = 1'b1;
    wr(`A_HCTRL, 8'h01);
    repeat (12) @(posedge clk) #1;
    chk("busy_held", 16'h0000, {15'h0, busy_out});
    bsy_in = 1'b0;
    for (k = 0; k < 16 && busy_out !== 1'b1; k++) @(posedge clk) #1;
    chk("arb_delay", 16'h0001, {15'h0, k >= 6 && k <= 10});
    rd(`A_HCTRL, 8'h01);
    sel_in = 1'b1;
    repeat (2) @(posedge clk) #1;
    chk("busy_sel", 16'h0000, {15'h0, busy_out});
    sel_in = 1'b0;
    wr(`A_HCTRL, 8'h40);
    chk("select_out", 16'h0001, {15'h0, select_out});
    wr(`A_HCTRL, 8'h00);
    wr(`A_RESET, 8'h00);
    setp(`A_STOP_L, 16'h0004);
    wr(`A_DMA, 8'h14);
    for (k = 0; k < 200 && (n_req < 4 || host_req !== 1'b0); k++) @(posedge clk) #1;
    repeat (20) @(posedge clk) #1;
    chk("req_count", 16'h0004, 16'(n_req));
    rd(`A_DMA, 8'h34);
    rd(`A_RAP_L, 8'h04);
    wr(`A_DMA, 8'h00);
    chk("pending", 16'h0000, 16'(exp_q.size()));
    wrap_up();
  end
endmodule : dual_port_buffer_manager_tb
